// ===== include/tclc_pkg.sv
`default_nettype none
package tclc_pkg;

  // Register port shape
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W = 32;

  // Register offsets
  localparam logic [3:0] OFF_TEMP = 4'h0;
  localparam logic [3:0] OFF_CONFIG = 4'h1;
  localparam logic [3:0] OFF_LIMIT_LO = 4'h2;
  localparam logic [3:0] OFF_LIMIT_HI = 4'h3;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFF_IRQ_ENABLE = 4'h5;
  localparam logic [3:0] OFF_IRQ_CLEAR = 4'h6;
  localparam logic [3:0] OFF_GCALL = 4'h7;

  // Configuration register fields
  localparam int CFG_MODE_LO = 0;
  localparam int CFG_MODE_HI = 1;
  localparam int CFG_LATCH = 2;
  localparam int CFG_OVER = 3;
  localparam int CFG_UNDER = 4;
  localparam int CFG_RATE_LO = 5;
  localparam int CFG_RATE_HI = 6;

  // Operating modes (op_mode_hi, op_mode_lo)
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;

  // Rate select codes
  localparam logic [1:0] RATE_0P25HZ = 2'h0;
  localparam logic [1:0] RATE_1HZ = 2'h1;
  localparam logic [1:0] RATE_4HZ = 2'h2;
  localparam logic [1:0] RATE_8HZ = 2'h3;

  // Reset values
  localparam logic [1:0] RST_MODE = MODE_CONT;
  localparam logic [1:0] RST_RATE = RATE_0P25HZ;
  localparam logic RST_LATCH = 1'b0;
  localparam logic RST_FLAG = 1'b0;
  localparam logic [7:0] RST_TEMP = 8'h00;
  localparam logic [7:0] RST_LIMIT_HI = 8'h3c;
  localparam logic [7:0] RST_LIMIT_LO = 8'h00;

  // Interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_CONV = 0;
  localparam int IRQ_OVER = 1;
  localparam int IRQ_UNDER = 2;

  // Soft reset command byte
  localparam logic [7:0] GCALL_RESET_CMD = 8'h06;

  // Timing: clock rate, conversion time and rate periods in their own units
  localparam int CLK_MHZ = 125;
  localparam int CONV_TIME_US = 26000;
  localparam int PERIOD_0P25HZ_MS = 4000;
  localparam int PERIOD_1HZ_MS = 1000;
  localparam int PERIOD_4HZ_MS = 250;
  localparam int PERIOD_8HZ_MS = 125;
  localparam logic [CNT_W-1:0] CONV_CYC = CNT_W'(CONV_TIME_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] PER_0P25HZ_CYC = CNT_W'(PERIOD_0P25HZ_MS * CLK_MHZ * 1000);
  localparam logic [CNT_W-1:0] PER_1HZ_CYC = CNT_W'(PERIOD_1HZ_MS * CLK_MHZ * 1000);
  localparam logic [CNT_W-1:0] PER_4HZ_CYC = CNT_W'(PERIOD_4HZ_MS * CLK_MHZ * 1000);
  localparam logic [CNT_W-1:0] PER_8HZ_CYC = CNT_W'(PERIOD_8HZ_MS * CLK_MHZ * 1000);

  // Conversion scheduler states, Gray along shutdown -> convert -> wait
  typedef enum logic [1:0] {
    ST_SHUT = 2'b00,
    ST_CONV = 2'b01,
    ST_WAIT = 2'b11
  } tclc_fsm_t;

endpackage
`default_nettype wire

// ===== core/tclc_conv_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tclc_conv_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic halt,
  input wire logic [tclc_pkg::CNT_W-1:0] conv_cycles,
  input wire logic [tclc_pkg::CNT_W-1:0] period_cycles,
  output logic conv_done,
  output logic period_done
);
  import tclc_pkg::*;

  typedef struct packed {
    logic run;
    logic [CNT_W-1:0] cnt;
  } tclc_tmr_t;

  // Runs from reset so the first conversion starts without being asked
  localparam tclc_tmr_t TMR_RST = '{run: 1'b1, cnt: '0};

  tclc_tmr_t q;
  tclc_tmr_t d;

  // Compare with >= on the period so a shorter rate written mid-wait cannot be skipped
  assign conv_done = q.run && (q.cnt == conv_cycles - CNT_W'(1));
  assign period_done = q.run && (q.cnt >= period_cycles - CNT_W'(1));

  // Counter: start has priority, halt parks it, a finished period stops it
  always_comb begin
    d = q;
    if (start) begin
      d.run = 1'b1;
      d.cnt = '0;
    end else if (halt) begin
      d.run = 1'b0;
      d.cnt = '0;
    end else if (period_done) begin
      d.run = 1'b0;
    end else if (q.run) begin
      d.cnt = q.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= TMR_RST;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// ===== core/tclc_core.sv
// Overview of operation
// (R01) A finished conversion above the high limit sets over_limit_flag to 1.
// (R02) A finished conversion below the low limit sets under_limit_flag to 1.
// (R03) With flag_latch_enable set, both flags hold until the configuration register is read.
// (R04) A configuration read clears both flags, as does an in-limit result with latching off.
// (R05) After reset both flags and flag_latch_enable are 0.
// (R06) Rate bits pick the continuous rate: 00 is 0.25 Hz (default), 01 1 Hz, 10 4 Hz, 11 8 Hz.
// (R07) Each period holds one 26 ms conversion, then the converter powers down until period end.
// (R08) After reset or a general-call reset a conversion starts at once, result 26 ms later.
// (R09) Writing mode 00 enters shutdown, but only after a running conversion has finished.
// (R10) In shutdown only the register port stays alive; the converter is unpowered.
// (R11) Writing mode 01 while shut down starts exactly one conversion.
// (R12) During a one-shot conversion the mode bits read 01.
// (R13) At the end of a one-shot the block shuts down by itself and the mode bits read 00.
// (R14) With op_mode_hi set the block converts repeatedly at the selected rate.
// (R15) A new one-shot is accepted as soon as the previous conversion ends.
// (R16) Writing command 00000110 to the general-call register restores all power-up values.
// (R17) The result register and the limit checks change only when a conversion completes.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tclc_core #(
  parameter logic [tclc_pkg::CNT_W-1:0] CONV_CYCLES = tclc_pkg::CONV_CYC,
  parameter logic [tclc_pkg::CNT_W-1:0] PERIOD_0P25HZ_CYCLES = tclc_pkg::PER_0P25HZ_CYC,
  parameter logic [tclc_pkg::CNT_W-1:0] PERIOD_1HZ_CYCLES = tclc_pkg::PER_1HZ_CYC,
  parameter logic [tclc_pkg::CNT_W-1:0] PERIOD_4HZ_CYCLES = tclc_pkg::PER_4HZ_CYC,
  parameter logic [tclc_pkg::CNT_W-1:0] PERIOD_8HZ_CYCLES = tclc_pkg::PER_8HZ_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [tclc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tclc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tclc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [tclc_pkg::DATA_W-1:0] adc_data,
  output logic conv_power,
  output logic over_limit_flag,
  output logic under_limit_flag,
  output logic irq
);
  import tclc_pkg::*;

  typedef struct packed {
    // Scheduler state and configuration bits
    tclc_fsm_t state;
    logic [1:0] op_mode;
    logic [1:0] rate_sel;
    logic flag_latch_enable;
    // Watchdog flags, result and limits
    logic over_limit_flag;
    logic under_limit_flag;
    logic [7:0] temp_result;
    logic [7:0] limit_hi;
    logic [7:0] limit_lo;
    // Interrupt status and enable
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    // Result pin synchroniser, three stages plus the accepted value
    logic [7:0] adc_s1;
    logic [7:0] adc_s2;
    logic [7:0] adc_s3;
    logic [7:0] adc_stable;
    // Registered copies of the read data and pin outputs
    logic [7:0] rdata;
    logic irq;
    logic conv_power;
  } tclc_regs_t;

  // Power-up image; the reset state is already converting
  localparam tclc_regs_t REGS_RST = '{
    state: ST_CONV,
    op_mode: RST_MODE,
    rate_sel: RST_RATE,
    flag_latch_enable: RST_LATCH,
    over_limit_flag: RST_FLAG,
    under_limit_flag: RST_FLAG,
    temp_result: RST_TEMP,
    limit_hi: RST_LIMIT_HI,
    limit_lo: RST_LIMIT_LO,
    irq_status: '0,
    irq_enable: '0,
    adc_s1: 8'h00,
    adc_s2: 8'h00,
    adc_s3: 8'h00,
    adc_stable: 8'h00,
    rdata: 8'h00,
    irq: 1'b0,
    conv_power: 1'b1
  };

  tclc_regs_t q;
  tclc_regs_t d;

  // Handshake with the conversion timer
  logic tmr_start;
  logic tmr_halt;
  logic conv_done;
  logic period_done;
  logic [CNT_W-1:0] period_cycles;

  // Address match, shared by the read and write decoders
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [3:0] off);
    hit = (addr == ADDR_W'(off));
  endfunction

  // Continuous-mode period for a rate code
  function automatic logic [CNT_W-1:0] rate_period(input logic [1:0] sel);
    unique case (sel)
      RATE_0P25HZ: rate_period = PERIOD_0P25HZ_CYCLES;
      RATE_1HZ: rate_period = PERIOD_1HZ_CYCLES;
      RATE_4HZ: rate_period = PERIOD_4HZ_CYCLES;
      RATE_8HZ: rate_period = PERIOD_8HZ_CYCLES;
    endcase
  endfunction

  // Configuration byte as software sees it
  function automatic logic [7:0] cfg_image(input tclc_regs_t r);
    cfg_image = 8'h00;
    cfg_image[CFG_MODE_LO] = r.op_mode[0];
    cfg_image[CFG_MODE_HI] = r.op_mode[1];
    cfg_image[CFG_LATCH] = r.flag_latch_enable;
    cfg_image[CFG_OVER] = r.over_limit_flag;
    cfg_image[CFG_UNDER] = r.under_limit_flag;
    cfg_image[CFG_RATE_LO] = r.rate_sel[0];
    cfg_image[CFG_RATE_HI] = r.rate_sel[1];
  endfunction

  // Period for the selected continuous rate; a new code acts on the running wait
  assign period_cycles = rate_period(q.rate_sel); // R06

  // One counter times both the conversion and the rest of the period
  tclc_conv_timer u_timer (
    .clk(clk),
    .rst(rst),
    .start(tmr_start),
    .halt(tmr_halt),
    .conv_cycles(CONV_CYCLES),
    .period_cycles(period_cycles),
    .conv_done(conv_done),
    .period_done(period_done)
  );

  // Next-state logic for every register of the block
  always_comb begin
    logic cfg_read;
    logic gcall;
    logic over_evt;
    logic under_evt;
    logic [IRQ_W-1:0] irq_set;
    logic conv_end;
    cfg_read = 1'b0;
    gcall = 1'b0;
    over_evt = 1'b0;
    under_evt = 1'b0;
    irq_set = '0;
    conv_end = conv_done && (q.state == ST_CONV); // R17
    d = q;
    tmr_start = 1'b0;
    tmr_halt = 1'b0;

    // Result pin sync: a change counts once stages two and three agree
    // Stage one may be metastable, so it is never compared itself
    d.adc_s1 = adc_data;
    d.adc_s2 = q.adc_s1;
    d.adc_s3 = q.adc_s2;
    if (q.adc_s2 == q.adc_s3) begin
      d.adc_stable = q.adc_s3;
    end

    // Register reads answer one cycle later; unmapped and write-only read as zero
    d.rdata = 8'h00;
    if (reg_rd) begin
      // Last completed result
      if (hit(reg_addr, OFF_TEMP)) begin
        d.rdata = q.temp_result;
      end

      // Configuration; reading it is also the flag acknowledge
      if (hit(reg_addr, OFF_CONFIG)) begin
        d.rdata = cfg_image(q); // R12 R13
        cfg_read = 1'b1;
      end

      // Limit registers read back as written
      if (hit(reg_addr, OFF_LIMIT_LO)) begin
        d.rdata = q.limit_lo;
      end
      if (hit(reg_addr, OFF_LIMIT_HI)) begin
        d.rdata = q.limit_hi;
      end

      // Interrupt status and enable share one layout
      if (hit(reg_addr, OFF_IRQ_STATUS)) begin
        d.rdata = 8'(q.irq_status);
      end
      if (hit(reg_addr, OFF_IRQ_ENABLE)) begin
        d.rdata = 8'(q.irq_enable);
      end
    end

    // Register writes; flags in the configuration byte are read-only
    if (reg_wr) begin
      // Mode, latch and rate; the scheduler below already sees a new mode
      if (hit(reg_addr, OFF_CONFIG)) begin
        d.op_mode = {reg_wdata[CFG_MODE_HI], reg_wdata[CFG_MODE_LO]};
        d.flag_latch_enable = reg_wdata[CFG_LATCH];
        d.rate_sel = {reg_wdata[CFG_RATE_HI], reg_wdata[CFG_RATE_LO]}; // R06
      end

      // Limits take effect at the next completed conversion
      if (hit(reg_addr, OFF_LIMIT_LO)) begin
        d.limit_lo = reg_wdata;
      end
      if (hit(reg_addr, OFF_LIMIT_HI)) begin
        d.limit_hi = reg_wdata;
      end

      // Enable, and write-one-to-clear for the sticky status
      if (hit(reg_addr, OFF_IRQ_ENABLE)) begin
        d.irq_enable = reg_wdata[IRQ_W-1:0];
      end
      if (hit(reg_addr, OFF_IRQ_CLEAR)) begin
        d.irq_status = q.irq_status & ~reg_wdata[IRQ_W-1:0];
      end

      // Soft reset only on the exact command byte; other values are ignored
      if (hit(reg_addr, OFF_GCALL) && (reg_wdata == GCALL_RESET_CMD)) begin
        gcall = 1'b1; // R16
      end
    end

    // Limit checks use only the captured end-of-conversion sample
    // Compare is signed: the result is two's complement degrees
    if (conv_end) begin
      d.temp_result = q.adc_stable; // R17
      over_evt = $signed(q.adc_stable) > $signed(q.limit_hi); // R01
      under_evt = $signed(q.adc_stable) < $signed(q.limit_lo); // R02
      irq_set[IRQ_CONV] = 1'b1;
      irq_set[IRQ_OVER] = over_evt;
      irq_set[IRQ_UNDER] = under_evt;
    end

    // Flags: read clears first, so a result landing in the same cycle still sets
    if (cfg_read) begin
      d.over_limit_flag = 1'b0; // R04
      d.under_limit_flag = 1'b0; // R04
    end
    if (conv_end) begin
      if (q.flag_latch_enable) begin
        d.over_limit_flag = d.over_limit_flag | over_evt; // R03
        d.under_limit_flag = d.under_limit_flag | under_evt; // R03
      end else begin
        d.over_limit_flag = over_evt; // R01 R04
        d.under_limit_flag = under_evt; // R02 R04
      end
    end

    // Scheduler; mode writes of this cycle are already in d.op_mode
    unique case (q.state)
      // Idle: only a mode write or a soft reset wakes the converter
      ST_SHUT: begin
        if (d.op_mode == MODE_ONESHOT) begin
          d.state = ST_CONV; // R11 R15
          tmr_start = 1'b1;
        end else if (d.op_mode[1]) begin
          d.state = ST_CONV; // R14
          tmr_start = 1'b1;
        end
      end

      ST_CONV: begin
        // Mode changes take effect only here, so a conversion is never cut short
        if (conv_done) begin
          if (d.op_mode == MODE_ONESHOT) begin
            d.op_mode = MODE_SHUTDOWN; // R13
            d.state = ST_SHUT;
            tmr_halt = 1'b1;
          end else if (d.op_mode[1]) begin
            d.state = ST_WAIT; // R07 R14
          end else begin
            d.state = ST_SHUT; // R09
            tmr_halt = 1'b1;
          end
        end
      end

      // Powered down between conversions of the continuous mode
      ST_WAIT: begin
        if (d.op_mode == MODE_ONESHOT) begin
          d.state = ST_CONV; // R11
          tmr_start = 1'b1;
        end else if (!d.op_mode[1]) begin
          d.state = ST_SHUT; // R09
          tmr_halt = 1'b1;
        end else if (period_done) begin
          d.state = ST_CONV; // R07 R14
          tmr_start = 1'b1;
        end
      end

      // Unused code: park in shutdown rather than guess
      default: begin
        d.state = ST_SHUT;
        tmr_halt = 1'b1;
      end
    endcase

    // Sticky status: a new event wins over a clear in the same cycle
    d.irq_status = d.irq_status | irq_set;

    // Soft reset restores the power-up image and restarts conversion; the
    // pin synchroniser keeps running so the next sample is not stale
    if (gcall) begin
      d = REGS_RST; // R05 R08 R16
      d.adc_s1 = adc_data;
      d.adc_s2 = q.adc_s1;
      d.adc_s3 = q.adc_s2;
      d.adc_stable = q.adc_stable;
      tmr_start = 1'b1; // R08
      tmr_halt = 1'b0;
    end

    // Converter is powered only while a conversion runs
    d.conv_power = (d.state == ST_CONV); // R07 R10
    d.irq = |(d.irq_status & d.irq_enable);
  end

  // Single state register; rst loads the same image as the soft reset
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= REGS_RST; // R05 R08
    end else begin
      q <= d;
    end
  end

  // All outputs straight from flip-flops
  assign reg_rdata = q.rdata;
  assign conv_power = q.conv_power;
  assign over_limit_flag = q.over_limit_flag;
  assign under_limit_flag = q.under_limit_flag;
  assign irq = q.irq;
endmodule
`default_nettype wire

// ===== tb/tclc_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tclc_core_assertions #(
  parameter logic [tclc_pkg::CNT_W-1:0] CONV_CYCLES = tclc_pkg::CONV_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [tclc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tclc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [tclc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [tclc_pkg::DATA_W-1:0] adc_data,
  input wire logic conv_power,
  input wire logic over_limit_flag,
  input wire logic under_limit_flag,
  input wire logic irq
);
  import tclc_pkg::*;
  logic [31:0] run_q;
  logic latch_q;
  logic gcall_wr;

  // Soft reset restarts a running conversion, so the run count starts over too
  assign gcall_wr = reg_wr && reg_addr == OFF_GCALL && reg_wdata == GCALL_RESET_CMD;

  // Powered run length and a shadow of the latch bit; reset clears both
  always_ff @(posedge clk) begin
    run_q <= (rst || !conv_power || gcall_wr) ? 32'h0 : run_q + 32'h1;
    if (rst) begin
      latch_q <= 1'b0;
    end else if (reg_wr && reg_addr == OFF_GCALL && reg_wdata == GCALL_RESET_CMD) begin
      latch_q <= 1'b0;
    end else if (reg_wr && reg_addr == OFF_CONFIG) begin
      latch_q <= reg_wdata[CFG_LATCH];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_reset_image;
    $fell(rst) |-> conv_power && !over_limit_flag && !under_limit_flag && !irq;
  endproperty
  a_reset_image: assert property (p_reset_image) else $error("bad state after reset");
  property p_conv_len;
    $fell(conv_power) |-> run_q inside {[CONV_CYCLES-1:CONV_CYCLES]};
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_rd_clear;
    reg_rd && reg_addr == OFF_CONFIG && !conv_power |=> !over_limit_flag && !under_limit_flag;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("flags survive config read");
  property p_flag_at_end;
    $rose(over_limit_flag) || $rose(under_limit_flag) |-> $fell(conv_power);
  endproperty
  a_flag_at_end: assert property (p_flag_at_end) else $error("flag set mid conversion");
  property p_latch_hold;
    latch_q && over_limit_flag && !(reg_rd && reg_addr == OFF_CONFIG)
      && !(reg_wr && reg_addr == OFF_GCALL) |=> over_limit_flag;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched flag dropped");
  property p_oneshot_start;
    reg_wr && reg_addr == OFF_CONFIG && reg_wdata[1:0] == MODE_ONESHOT && !conv_power
      |=> conv_power;
  endproperty
  a_oneshot_start: assert property (p_oneshot_start) else $error("one-shot did not start");
  property p_shut_quiet;
    reg_wr && reg_addr == OFF_CONFIG && reg_wdata[1:0] == MODE_SHUTDOWN && !conv_power
      |=> !conv_power [*8];
  endproperty
  a_shut_quiet: assert property (p_shut_quiet) else $error("converter woke in shutdown");
  property p_gcall;
    reg_wr && reg_addr == OFF_GCALL && reg_wdata == GCALL_RESET_CMD
      |=> conv_power && !over_limit_flag && !under_limit_flag && !irq;
  endproperty
  a_gcall: assert property (p_gcall) else $error("soft reset image wrong");
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
endmodule

bind tclc_core tclc_core_assertions #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .clk(clk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .adc_data(adc_data),
  .conv_power(conv_power),
  .over_limit_flag(over_limit_flag),
  .under_limit_flag(under_limit_flag),
  .irq(irq)
);
`default_nettype wire

// ===== tb/tclc_host.sv
`timescale 1ns/1ps
`default_nettype none
module tclc_host (
  input wire logic clk,
  output logic [tclc_pkg::ADDR_W-1:0] reg_addr,
  output logic [tclc_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [tclc_pkg::DATA_W-1:0] reg_rdata
);
  import tclc_pkg::*;

  // Idle bus at time zero
  initial begin
    reg_addr <= '0;
    reg_wdata <= '0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  end

  // One-cycle write; released lines show inverted junk, never the old value
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask

  // One-cycle read; data is only valid in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== tb/tclc_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tclc_core_bench;
  import tclc_pkg::*;
  localparam logic [CNT_W-1:0] CV = 32'h14;
  localparam int PER [4] = '{200, 100, 60, 40};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adc = 8'h10;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  logic wr, rd, pwr, ovr, und, irq;
  int errors = 0;
  int checks_done = 0;
  int n1, n2;

  always #4 clk = ~clk;

  tclc_core #(.CONV_CYCLES(CV), .PERIOD_0P25HZ_CYCLES(32'hc8), .PERIOD_1HZ_CYCLES(32'h64),
    .PERIOD_4HZ_CYCLES(32'h3c), .PERIOD_8HZ_CYCLES(32'h28)) uut (.clk(clk), .rst(rst),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .adc_data(adc), .conv_power(pwr), .over_limit_flag(ovr), .under_limit_flag(und), .irq(irq));
  tclc_host host (.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata));

  task automatic complete_run;
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Bounded wait for the converter power level; a hang ends the run
  task automatic wait_pwr(input logic lvl, output int n);
    n = 0;
    while (pwr !== lvl) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 1000) begin
        errors++;
        complete_run();
      end
    end
  endtask

  task automatic conv;
    wait_pwr(1'b1, n1);
    wait_pwr(1'b0, n1);
  endtask

  task automatic rdchk(input string what, input logic [3:0] a, input logic [7:0] exp);
    host.rd(a, d);
    chk(what, d, exp);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    rdchk("cfg_rst", OFF_CONFIG, 8'h02);
    wait_pwr(1'b0, n1);
    rdchk("temp_first", OFF_TEMP, 8'h10);
    // Every rate code: fixed conversion inside each period
    for (int r = 0; r < 4; r++) begin
      host.wr(OFF_CONFIG, {1'b0, 2'(r), 4'h1, 1'(r)});
      wait_pwr(1'b0, n1);
      wait_pwr(1'b1, n1);
      wait_pwr(1'b0, n1);
      wait_pwr(1'b1, n2);
      chk("conv_len", n1, CV);
      chk("period", n1 + n2, PER[r]);
    end
    // Without latching each result rewrites the flags; compare is signed
    host.wr(OFF_LIMIT_HI, 8'h20);
    host.wr(OFF_LIMIT_LO, 8'h08);
    host.wr(OFF_IRQ_ENABLE, 8'h02);
    adc <= 8'h30;
    conv();
    chk("over_irq", {ovr, und, irq}, 3'b101);
    adc <= 8'hf0;
    conv();
    chk("under", {ovr, und}, 2'b01);
    rdchk("sts", OFF_IRQ_STATUS, 8'h07);
    host.wr(OFF_IRQ_CLEAR, 8'h07);
    rdchk("sts_clr", OFF_IRQ_STATUS, 8'h00);
    adc <= 8'h10;
    conv();
    chk("inside", {ovr, und, irq}, 3'b000);
    // With latching a flag outlives an in-range result until the config read
    host.wr(OFF_CONFIG, 8'h66);
    adc <= 8'h30;
    conv();
    adc <= 8'h10;
    conv();
    chk("held", ovr, 1'b1);
    rdchk("cfg_latched", OFF_CONFIG, 8'h6e);
    chk("rd_clr", ovr, 1'b0);
    wait_pwr(1'b1, n1);
    adc <= 8'h22;
    rdchk("temp_mid", OFF_TEMP, 8'h10);
    wait_pwr(1'b0, n1);
    rdchk("temp_end", OFF_TEMP, 8'h22);
    // Shutdown asked mid-conversion waits for its end, then the port stays alive
    wait_pwr(1'b1, n1);
    host.wr(OFF_CONFIG, 8'h00);
    chk("shut_busy", pwr, 1'b1);
    wait_pwr(1'b0, n1);
    repeat (60) @(posedge clk);
    #1;
    chk("shut_idle", pwr, 1'b0);
    host.wr(OFF_LIMIT_HI, 8'h40);
    rdchk("shut_port", OFF_LIMIT_HI, 8'h40);
    // Two one-shots in a row; mode bits track the running conversion
    for (int k = 0; k < 2; k++) begin
      host.wr(OFF_CONFIG, 8'h01);
      chk("os_run", pwr, 1'b1);
      host.rd(OFF_CONFIG, d);
      chk("os_mode", d[1:0], 2'b01);
      wait_pwr(1'b0, n1);
      host.rd(OFF_CONFIG, d);
      chk("os_done", d[1:0], 2'b00);
    end
    host.wr(OFF_CONFIG, 8'h00);
    repeat (60) @(posedge clk);
    #1;
    chk("os_single", pwr, 1'b0);
    // Only the reset command byte restores power-up values
    host.wr(OFF_CONFIG, 8'h46);
    host.wr(OFF_GCALL, 8'h05);
    rdchk("gc_other", OFF_LIMIT_HI, 8'h40);
    // Let the conversion end so the restart below is visible on the power pin
    wait_pwr(1'b0, n1);
    host.wr(OFF_GCALL, GCALL_RESET_CMD);
    chk("gc_conv", pwr, 1'b1);
    rdchk("gc_cfg", OFF_CONFIG, 8'h02);
    rdchk("gc_hi", OFF_LIMIT_HI, RST_LIMIT_HI);
    rdchk("unmapped", 4'h9, 8'h00);
    rdchk("clear_wo", OFF_IRQ_CLEAR, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
